// ### core/stc_delay_comp.sv
// Propagation delay compensation from the decade switches
module stc_delay_comp (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [35:0] switches,
  input  wire logic [1:0]  sat_id,
  output logic      [9:0]  comp,
  output logic             sat_change
);
  logic [9:0] grp_sum [3];
  logic [1:0] sat_last;

  // One sum per satellite group, digits weighted 100, 10 and 1 steps
  for (genvar g = 0; g < 3; g++) begin : g_grp
    assign grp_sum[g] = 10'(switches[12*g+8 +: 4]) * 10'h64
                      + 10'(switches[12*g+4 +: 4]) * 10'h0A
                      + 10'(switches[12*g   +: 4]);
  end

  assign sat_change = (sat_id != sat_last);

  // Spare code 3 falls back on the spare group as well
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      comp     <= 10'h000;
      sat_last <= 2'h0;
    end else begin
      sat_last <= sat_id;
      comp     <= grp_sum[(sat_id > 2'h2) ? 2'h2 : sat_id];
    end
  end

  a_comp_follow: assert property (@(posedge clk) disable iff (!rst_b)
    $stable(switches) && sat_id < 2'h3 |=> comp == $past(grp_sum[sat_id]))
    else $error("compensation does not follow the selected group");
endmodule : stc_delay_comp

// ### core/stc_pkg.sv
// Constants and types for the sync status and time correction block
// Behaviour
// - Status query gets one hex or asterisk reply
// - Asterisk reply while not synchronised
// - Low three bits carry accuracy value N
// - Parity error adds eight to reply
// - Decode two summer-time bits from time code
// - Zero hours offset ignores summer-time bits
// - Offsets -4 to -11 shift local time automatically
// - Switch OFF enables shift, ON inhibits
// - Nine decade switches, three per satellite
// - Digit weights 10, 1.0 and 0.1 ms
// - Apply identified satellite compensation, 100 us steps
// - Drive seek, lock and fine/coarse loop switches
// - Coarse after 3 s, fine after 32 s
// - Loss-of-lock bit after 150 s carrier loss
package stc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ       = 64'd25_000_000;
  localparam longint RF_WAIT_S    = 64'd3;
  localparam longint DLOCK_S      = 64'd32;
  localparam longint LOL_S        = 64'd150;
  localparam longint RF_WAIT_CYC  = RF_WAIT_S * CLK_HZ;
  localparam longint DLOCK_CYC    = DLOCK_S * CLK_HZ;
  localparam longint LOL_CYC      = LOL_S * CLK_HZ;
  // ----------------------------------------------------------------
  // Serial characters and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_QUERY   = 8'h53;
  localparam logic [7:0] CH_ASTER   = 8'h2A;
  localparam logic [7:0] CH_DIGIT0  = 8'h30;
  localparam logic [7:0] CH_LETTERA = 8'h37;
  localparam logic [3:0] HEX_TEN    = 4'hA;
  localparam logic [1:0] SUMMER_ON  = 2'h3;
  localparam logic signed [4:0] OFFS_ZERO = 5'sh00;
  localparam logic signed [4:0] OFFS_HI   = 5'sh1C;
  localparam logic signed [4:0] OFFS_LO   = 5'sh15;
  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATE  = 8'h04;
  localparam logic [7:0] A_IRQ_ST = 8'h08;
  localparam logic [7:0] A_IRQ_MK = 8'h0C;
  localparam logic [0:0] CTRL_RST = 1'h1;
  localparam int         N_IRQ    = 4;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Loop state, Gray coded along seek, wait, coarse, track
  typedef enum logic [1:0] {
    LP_SEEK   = 2'h0,
    LP_WAIT   = 2'h1,
    LP_COARSE = 2'h3,
    LP_TRACK  = 2'h2
  } stc_loop_type;
endpackage : stc_pkg

// ### core/stc_timer.sv
// Interval timer: done once enable has held for limit cycles
module stc_timer (
  input wire logic  clk,
  input wire logic  rst_b,
  stc_tmr_if.timer  t
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;

  // Saturate at the limit so done stays up while enable holds
  assign next_cnt = !t.en ? 32'h0 : (cnt == t.limit) ? cnt : cnt + 32'h1;
  assign t.done   = t.en && (cnt == t.limit);

  // Counter register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 32'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  a_timer_done: assert property (@(posedge clk) disable iff (!rst_b)
    t.done |-> $past(t.en)) else $error("timer done without enable");
endmodule : stc_timer

// ### core/stc_tmr_if.sv
// Interface between the block and one of its interval timers
interface stc_tmr_if;
  logic        en;
  logic        done;
  logic [31:0] limit;
  modport owner (output en, output limit, input done);
  modport timer (input en, input limit, output done);
endinterface : stc_tmr_if

// ### core/stc_top.sv
// Sync status reply, summer time, delay compensation and loop control
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
module stc_top #(
  parameter logic [31:0] RF_WAIT_CYC = 32'(stc_pkg::RF_WAIT_CYC),
  parameter logic [31:0] DLOCK_CYC   = 32'(stc_pkg::DLOCK_CYC),
  parameter logic [31:0] LOL_CYC     = 32'(stc_pkg::LOL_CYC)
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_B,
  // AXI4-Lite slave
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  output logic                   IRQ,
  // Serial character stream
  input  wire logic [7:0]        RX_CHAR,
  input  wire logic              RX_VALID,
  output logic [7:0]             TX_CHAR,
  output logic                   TX_VALID,
  // Receiver status
  input  wire logic              SYNC_OK,
  input  wire logic [2:0]        ACCURACY,
  input  wire logic              POS_PARITY_ERR,
  input  wire logic [1:0]        SUMMER_BITS,
  input  wire logic signed [4:0] HOURS_OFFSET,
  input  wire logic              SUMMER_SW_ON,
  output logic                   SUMMER_TIME_SHIFT,
  // Delay switches, nibbles: east, west, spare; 10, 1.0, 0.1 ms
  input  wire logic [35:0]       DELAY_SW,
  input  wire logic [1:0]        SAT_ID,
  output logic [9:0]             DELAY_COMP,
  // Data loop
  input  wire logic              RF_LOCK,
  input  wire logic              DATA_LOCK,
  input  wire logic              CARRIER_LOCK,
  input  wire logic              CE4_SLOT,
  output logic                   SEEK_TRACE,
  output logic                   LOCK_FREEZE,
  output logic                   FINE_COARSE1,
  output logic                   FINE_COARSE2,
  output logic                   LOCK_LOST,
  output logic                   TC_LOSS_BIT
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  stc_pkg::stc_loop_type state;
  stc_pkg::stc_loop_type next_state;
  stc_tmr_if             rf_t ();
  stc_tmr_if             dl_t ();
  stc_tmr_if             cl_t ();
  localparam int         N_IRQ_W = stc_pkg::N_IRQ;
  logic                  query_en;
  logic [N_IRQ_W-1:0]    irq_st;
  logic [N_IRQ_W-1:0]    irq_mk;
  logic [N_IRQ_W-1:0]    irq_ev;
  logic [N_IRQ_W-1:0]    next_irq_st;
  logic                  query_hit;
  logic [3:0]            code;
  logic [7:0]            next_char;
  logic                  offs_zone;
  logic                  summer_force;
  logic                  sat_change;
  logic                  wr_go;
  logic                  rd_go;
  logic                  wr_ctrl;
  logic                  wr_mask;
  logic                  wr_ok;
  logic                  rd_ok;
  logic                  rd_clear;
  logic [31:0]           rd_word;
  logic                  coarse_entry;
  logic                  lost_set;

  // ----------------------------------------------------------------
  // Status query reply
  // ----------------------------------------------------------------
  // Parity weight sits in bit 3, accuracy in the low bits
  assign query_hit = RX_VALID && query_en && (RX_CHAR == stc_pkg::CH_QUERY);
  assign code      = {POS_PARITY_ERR, ACCURACY};
  assign next_char = !SYNC_OK ? stc_pkg::CH_ASTER
                   : (code < stc_pkg::HEX_TEN)
                     ? stc_pkg::CH_DIGIT0 + 8'(code)
                     : stc_pkg::CH_LETTERA + 8'(code);

  // One character per query, held until the next query
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_CHAR  <= stc_pkg::CH_ASTER;
      TX_VALID <= 1'b0;
    end else begin
      TX_VALID <= query_hit;
      if (query_hit) begin
        TX_CHAR <= next_char;
      end
    end
  end

  a_reply_once: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    query_hit |=> TX_VALID ##1 !TX_VALID || $past(query_hit))
    else $error("status reply not a single character");
  a_reply_unsync: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    query_hit && !SYNC_OK |=> TX_CHAR == stc_pkg::CH_ASTER)
    else $error("unsynchronised reply is not an asterisk");
  a_reply_code: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    query_hit && SYNC_OK && POS_PARITY_ERR && ACCURACY == 3'h3
    |=> TX_CHAR == 8'h42)
    else $error("accuracy with parity did not give B");

  // ----------------------------------------------------------------
  // Summer time correction
  // ----------------------------------------------------------------
  // Offset zero keeps universal time; west offsets -4..-11 follow
  // the broadcast flag unless the board switch inhibits it
  assign offs_zone = (HOURS_OFFSET <= stc_pkg::OFFS_HI) &&
                     (HOURS_OFFSET >= stc_pkg::OFFS_LO);
  assign summer_force = (SUMMER_BITS == stc_pkg::SUMMER_ON);

  // Registered so the time path sees a clean level
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SUMMER_TIME_SHIFT <= 1'b0;
    end else begin
      SUMMER_TIME_SHIFT <= summer_force && offs_zone && !SUMMER_SW_ON;
    end
  end

  a_utc_kept: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    HOURS_OFFSET == stc_pkg::OFFS_ZERO |=> !SUMMER_TIME_SHIFT)
    else $error("universal time was shifted");
  a_switch_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    summer_force && offs_zone |=> SUMMER_TIME_SHIFT == !$past(SUMMER_SW_ON))
    else $error("summer time switch sense wrong");

  // ----------------------------------------------------------------
  // Delay compensation
  // ----------------------------------------------------------------
  stc_delay_comp u_comp (
    .clk        (SYS_CLK),
    .rst_b      (RST_B),
    .switches   (DELAY_SW),
    .sat_id     (SAT_ID),
    .comp       (DELAY_COMP),
    .sat_change (sat_change)
  );

  // ----------------------------------------------------------------
  // Data loop control
  // ----------------------------------------------------------------
  // Three interval timers: wait for data lock, hold of data lock,
  // and carrier loss
  assign rf_t.en    = (state == stc_pkg::LP_WAIT) && !DATA_LOCK;
  assign rf_t.limit = RF_WAIT_CYC;
  assign dl_t.en    = (state == stc_pkg::LP_COARSE) && DATA_LOCK;
  assign dl_t.limit = DLOCK_CYC;
  assign cl_t.en    = !CARRIER_LOCK;
  assign cl_t.limit = LOL_CYC;

  stc_timer u_rf_tmr (.clk(SYS_CLK), .rst_b(RST_B), .t(rf_t));
  stc_timer u_dl_tmr (.clk(SYS_CLK), .rst_b(RST_B), .t(dl_t));
  stc_timer u_cl_tmr (.clk(SYS_CLK), .rst_b(RST_B), .t(cl_t));

  // Next loop state; loss of RF lock always returns to seek
  always_comb begin
    next_state = state;
    case (state)
      stc_pkg::LP_SEEK: begin
        if (RF_LOCK) next_state = stc_pkg::LP_WAIT;
      end
      stc_pkg::LP_WAIT: begin
        if (!RF_LOCK) next_state = stc_pkg::LP_SEEK;
        else if (DATA_LOCK) next_state = stc_pkg::LP_TRACK;
        else if (rf_t.done) next_state = stc_pkg::LP_COARSE;
      end
      stc_pkg::LP_COARSE: begin
        if (!RF_LOCK) next_state = stc_pkg::LP_SEEK;
        else if (dl_t.done) next_state = stc_pkg::LP_TRACK;
      end
      stc_pkg::LP_TRACK: begin
        if (!RF_LOCK) next_state = stc_pkg::LP_SEEK;
      end
      default: next_state = stc_pkg::LP_SEEK;
    endcase
  end

  assign coarse_entry = (next_state == stc_pkg::LP_COARSE) &&
                        (state != stc_pkg::LP_COARSE);
  assign lost_set     = cl_t.done && !LOCK_LOST;

  // Switch drive is registered from the next state so all four
  // change on the same edge and never glitch against each other
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state        <= stc_pkg::LP_SEEK;
      SEEK_TRACE   <= 1'b1;
      LOCK_FREEZE  <= 1'b1;
      FINE_COARSE1 <= 1'b1;
      FINE_COARSE2 <= 1'b0;
    end else begin
      state        <= next_state;
      SEEK_TRACE   <= (next_state == stc_pkg::LP_SEEK);
      LOCK_FREEZE  <= (next_state != stc_pkg::LP_COARSE);
      FINE_COARSE1 <= (next_state != stc_pkg::LP_COARSE);
      FINE_COARSE2 <= (next_state == stc_pkg::LP_COARSE);
    end
  end

  // Loss-of-lock level, placed in the code at control element 4
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LOCK_LOST   <= 1'b0;
      TC_LOSS_BIT <= 1'b0;
    end else begin
      LOCK_LOST   <= cl_t.done;
      TC_LOSS_BIT <= cl_t.done && CE4_SLOT;
    end
  end

  a_coarse_paths: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == stc_pkg::LP_COARSE |-> !LOCK_FREEZE && FINE_COARSE2 && !FINE_COARSE1)
    else $error("coarse path switches wrong");
  a_seek_drive: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !RF_LOCK |=> SEEK_TRACE && state == stc_pkg::LP_SEEK)
    else $error("seek not driven without RF lock");
  a_lol_bit: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CARRIER_LOCK |=> !LOCK_LOST && !TC_LOSS_BIT)
    else $error("loss of lock shown with carrier present");
  a_fine_restore: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == stc_pkg::LP_COARSE && RF_LOCK && dl_t.done
    |=> state == stc_pkg::LP_TRACK && LOCK_FREEZE && FINE_COARSE1)
    else $error("fine path not restored after data lock");

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // Events: 0 query answered, 1 coarse entered, 2 lock lost,
  // 3 satellite changed; a new event beats the read clear
  assign irq_ev      = {sat_change, lost_set, coarse_entry, query_hit};
  assign next_irq_st = (rd_clear ? '0 : irq_st) | irq_ev;
  assign IRQ         = |(irq_st & irq_mk);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_st <= '0;
    end else begin
      irq_st <= next_irq_st;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are taken together, one write at a time
  assign wr_go   = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY  = wr_go;
  assign wr_ctrl = wr_go && S_AXI_WSTRB[0] && (S_AXI_AWADDR == stc_pkg::A_CTRL);
  assign wr_mask = wr_go && S_AXI_WSTRB[0] && (S_AXI_AWADDR == stc_pkg::A_IRQ_MK);
  assign wr_ok   = (S_AXI_AWADDR == stc_pkg::A_CTRL) ||
                   (S_AXI_AWADDR == stc_pkg::A_STATE) ||
                   (S_AXI_AWADDR == stc_pkg::A_IRQ_ST) ||
                   (S_AXI_AWADDR == stc_pkg::A_IRQ_MK);
  assign rd_go   = S_AXI_ARVALID && !S_AXI_RVALID;
  assign S_AXI_ARREADY = rd_go;
  assign rd_clear = rd_go && (S_AXI_ARADDR == stc_pkg::A_IRQ_ST);
  assign rd_ok   = (S_AXI_ARADDR == stc_pkg::A_CTRL) ||
                   (S_AXI_ARADDR == stc_pkg::A_STATE) ||
                   (S_AXI_ARADDR == stc_pkg::A_IRQ_ST) ||
                   (S_AXI_ARADDR == stc_pkg::A_IRQ_MK);
  assign rd_word = (S_AXI_ARADDR == stc_pkg::A_CTRL)   ? {31'h0, query_enable_w()}
                 : (S_AXI_ARADDR == stc_pkg::A_STATE)  ? {16'h0, DELAY_COMP,
                     LOCK_LOST, SUMMER_TIME_SHIFT, SYNC_OK, 1'b0, state}
                 : (S_AXI_ARADDR == stc_pkg::A_IRQ_ST) ? {28'h0, irq_st}
                 : (S_AXI_ARADDR == stc_pkg::A_IRQ_MK) ? {28'h0, irq_mk}
                 : 32'h0;

  function automatic logic query_enable_w();
    return query_en;
  endfunction : query_enable_w

  // Control and mask registers
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      query_en <= stc_pkg::CTRL_RST[0];
      irq_mk   <= '0;
    end else begin
      if (wr_ctrl) query_en <= S_AXI_WDATA[0];
      if (wr_mask) irq_mk   <= S_AXI_WDATA[N_IRQ_W-1:0];
    end
  end

  // Write response; unmapped offsets answer with a slave error
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= stc_pkg::RESP_OK;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_ok ? stc_pkg::RESP_OK : stc_pkg::RESP_ERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read data captured on the address handshake
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= stc_pkg::RESP_OK;
    end else if (rd_go) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= rd_ok ? stc_pkg::RESP_OK : stc_pkg::RESP_ERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  a_irq_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    query_hit |=> irq_st[0]) else $error("query event not recorded");
endmodule : stc_top

// ### tb/stc_host_model.sv
// Serial host terminal model: sends characters and catches the replies
module stc_host_model (
  input  wire logic       clk,
  output logic      [7:0] rx_char,
  output logic            rx_valid,
  input  wire logic [7:0] tx_char,
  input  wire logic       tx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Character sender
  // ----------------------------------------------------------------
  initial begin
    rx_char  = 8'h00;
    rx_valid = 1'h0;
  end
  // One strobe per char; the reply stands one cycle, so it is caught then
  task automatic send(input logic [7:0] c, output logic [7:0] rep, output logic got);
    @(posedge clk);
    rx_char  <= c;
    rx_valid <= 1'h1;
    @(posedge clk);
    rx_valid <= 1'h0;
    rx_char  <= ~c; // Idle line must not keep echoing the last char
    @(posedge clk);
    got = tx_valid;
    rep = tx_char;
  endtask : send
endmodule : stc_host_model

// ### tb/sync_status_and_time_correction_tb.sv
// Self-checking bench for the sync status and time correction block
module sync_status_and_time_correction_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals, tables and tasks
  // ----------------------------------------------------------------
  logic        clk = 1'h0, rst_b = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, sync_ok = 1'h0, parity = 1'h0, sw_on = 1'h0;
  logic        rf_lock = 1'h0, data_lock = 1'h0, carrier = 1'h1, ce4 = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rx_char, tx_char, rep;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rs, sbits = 2'h0, sat_id = 2'h0;
  logic [2:0]  acc = 3'h0;
  logic signed [4:0] offs = 5'sh00;
  logic [35:0] dsw = 36'h999129374; // Spare 99.9, west 12.9, east 37.4 ms
  logic [9:0]  comp;
  logic        awready, wready, bvalid, arready, rvalid, irq, rx_valid, tx_valid, shift, got;
  logic        seek, lfreeze, fc1, fc2, lost, tc_loss;
  int          mismatches = 0, total_checks = 0;
  // Summer time cases: offsets -4, -11, 0, -3, -12, -5, -5, -5
  logic [1:0]  t_bits [8] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h1};
  logic [4:0]  t_offs [8] = '{5'h1C, 5'h15, 5'h00, 5'h1D, 5'h14, 5'h1B, 5'h1B, 5'h1B};
  logic [7:0]  t_sw = 8'h20, t_exp = 8'h03;
  logic [9:0]  d_exp [4] = '{10'h176, 10'h081, 10'h3E7, 10'h3E7};

  // Short counts so the loop timers finish within the run
  stc_top #(.RF_WAIT_CYC(32'h14), .DLOCK_CYC(32'h28), .LOL_CYC(32'h3C)) u_dut (
    .SYS_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ(irq), .RX_CHAR(rx_char), .RX_VALID(rx_valid), .TX_CHAR(tx_char), .TX_VALID(tx_valid),
    .SYNC_OK(sync_ok), .ACCURACY(acc), .POS_PARITY_ERR(parity), .SUMMER_BITS(sbits),
    .HOURS_OFFSET(offs), .SUMMER_SW_ON(sw_on), .SUMMER_TIME_SHIFT(shift), .DELAY_SW(dsw),
    .SAT_ID(sat_id), .DELAY_COMP(comp), .RF_LOCK(rf_lock), .DATA_LOCK(data_lock),
    .CARRIER_LOCK(carrier), .CE4_SLOT(ce4), .SEEK_TRACE(seek), .LOCK_FREEZE(lfreeze),
    .FINE_COARSE1(fc1), .FINE_COARSE2(fc2), .LOCK_LOST(lost), .TC_LOSS_BIT(tc_loss));
  stc_host_model u_host (.clk(clk), .rx_char(rx_char), .rx_valid(rx_valid),
    .tx_char(tx_char), .tx_valid(tx_valid));

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  // Compare and report; case inequality so an unknown never matches
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  // Write: address and data offered together, response awaited with bready up
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do @(posedge clk); while (!(awready === 1'h1 && wready === 1'h1));
    awvalid <= 1'h0;
    wvalid  <= 1'h0;
    do @(posedge clk); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : axi_wr
  // Read: data taken at the edge where rvalid is seen
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : axi_rd
  // Send one char and check whether a reply came and what it was
  task automatic ask(input logic [7:0] c, input logic g, input logic [7:0] e);
    u_host.send(c, rep, got);
    chk(32'(got), 32'(g), "reply presence");
    if (g) chk(32'(rep), 32'(e), "reply char");
  endtask : ask
  // Single exit point for the normal end and the watchdog
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // Whole run is near 300 cycles; far beyond that means a hang
  initial begin
    repeat (8000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    axi_rd(8'h00, rd, rs);
    chk(rd, 32'h1, "control reset value");
    axi_rd(8'h10, rd, rs);
    chk({rd, rs} == {32'h0, stc_pkg::RESP_ERR}, 1, "unmapped read");
    axi_wr(8'h10, 32'h1, rs);
    chk(32'(rs), 32'(stc_pkg::RESP_ERR), "unmapped write");
    $display("Test registers done");
    // Unsynchronised: asterisk even with parity and accuracy set
    parity <= 1'h1;
    acc    <= 3'h5;
    ask(8'h53, 1'h1, 8'h2A);
    sync_ok <= 1'h1;
    for (int v = 0; v < 16; v++) begin
      acc    <= v[2:0];
      parity <= v[3];
      ask(8'h53, 1'h1, 8'(v < 10 ? 8'h30 + v : 8'h37 + v));
    end
    ask(8'h54, 1'h0, 8'h00);
    axi_wr(8'h00, 32'h0, rs);
    ask(8'h53, 1'h0, 8'h00);
    axi_wr(8'h00, 32'h1, rs);
    $display("Test status reply done");
    // Interrupt raised by an answered query, cleared by reading status;
    // earlier queries left status set, so clear it before unmasking
    acc    <= 3'h3;
    axi_rd(8'h08, rd, rs);
    axi_wr(8'h0C, 32'h1, rs);
    chk(32'(irq), 32'h0, "irq idle");
    ask(8'h53, 1'h1, 8'h42);
    @(posedge clk);
    chk(32'(irq), 32'h1, "irq raised");
    axi_rd(8'h08, rd, rs);
    chk(32'(rd[0]), 32'h1, "irq status bit");
    @(posedge clk);
    chk(32'(irq), 32'h0, "irq cleared");
    axi_wr(8'h0C, 32'h0, rs);
    ask(8'h53, 1'h1, 8'h42);
    @(posedge clk);
    chk(32'(irq), 32'h0, "irq masked");
    $display("Test interrupt done");
    for (int i = 0; i < 8; i++) begin
      sbits <= t_bits[i];
      offs  <= t_offs[i];
      sw_on <= t_sw[i];
      repeat (3) @(posedge clk);
      chk(32'(shift), 32'(t_exp[i]), "summer shift");
    end
    for (int s = 0; s < 4; s++) begin
      sat_id <= 2'(s);
      repeat (3) @(posedge clk);
      chk(32'(comp), 32'(d_exp[s]), "delay comp");
    end
    $display("Test time correction done");
    // Acquisition: wait for data lock, fall to coarse, return to fine
    rf_lock <= 1'h1;
    repeat (3) @(posedge clk);
    chk(32'(seek), 32'h0, "seek released");
    repeat (10) @(posedge clk);
    chk(32'(lfreeze), 32'h1, "not coarse yet");
    repeat (17) @(posedge clk);
    chk({lfreeze, fc2, fc1}, 32'h2, "coarse path");
    data_lock <= 1'h1;
    repeat (25) @(posedge clk);
    chk({lfreeze, fc2, fc1}, 32'h2, "still coarse");
    repeat (25) @(posedge clk);
    chk({lfreeze, fc2, fc1}, 32'h5, "fine path");
    carrier <= 1'h0;
    repeat (40) @(posedge clk);
    chk(32'(lost), 32'h0, "lock not lost yet");
    repeat (35) @(posedge clk);
    chk(32'(lost), 32'h1, "lock lost");
    ce4 <= 1'h1;
    repeat (3) @(posedge clk);
    chk(32'(tc_loss), 32'h1, "loss bit in slot");
    ce4     <= 1'h0;
    carrier <= 1'h1;
    repeat (3) @(posedge clk);
    chk({lost, tc_loss}, 32'h0, "lock regained");
    // Tracking, synchronised, no shift, spare group compensation 99.9 ms
    axi_rd(8'h04, rd, rs);
    chk(rd, 32'h0000F9CA, "state register");
    $display("Test loop control done");
    end_sim();
  end
endmodule : sync_status_and_time_correction_tb
